// ### common/brc_pkg.sv
// Constants and carrier types for the board reset control block.
// Assumes a single 250 MHz clock and synchronous active-high reset.
// Contract
// - Watch panel, bridge, I/O and processor reset sources; sequence all resets.
// - Perform power-up reset when power is first applied.
// - Assert panel power-good 30 to 40 ms after supply power-good.
// - Panel hard reset goes to bridge via power microcontroller, not buses.
// - Any hard reset asserts both ISA bus reset and PCI reset.
// - ISA bus reset resets ISA subsystem; PCI reset resets PCI bus.
// - Host bridge passes PCI reset on to reset the processors.
// - Keyboard and chipset soft resets merge into one processor init.
package brc_pkg;
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned PG_DELAY_MS    = 30;
  localparam int unsigned PG_MAX_MS      = 40;
  // Least time rounds up; exact here
  localparam int unsigned PG_DELAY_CYC   = PG_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned HARD_RST_MS    = 1;
  localparam int unsigned HARD_RST_CYC   = HARD_RST_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W          = 24;

  typedef enum logic [1:0] {
    BRC_OFF     = 2'b00,
    BRC_WAIT_PG = 2'b01,
    BRC_RUN     = 2'b10,
    BRC_HARD    = 2'b11
  } brc_state_t;

  typedef struct packed {
    logic isa_bus_reset;
    logic pci_reset;
    logic cpu_reset;
  } brc_hard_t;
endpackage : brc_pkg

// ### verilog/brc_sync.sv
// Two-flop synchroniser for a vector of board pins.
// Assumes inputs are asynchronous to clock.
`timescale 1ns/1ns
module brc_sync
  import brc_pkg::*;
#(
  parameter int unsigned W   = 1,
  parameter logic [W-1:0] INIT = '0
)(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : brc_sync

// ### verilog/brc_top.sv
// Board reset sequencer: power-good delay, hard reset fan-out, soft merge.
// Assumes all request pins are asynchronous and active low.
`timescale 1ns/1ns
module brc_top
  import brc_pkg::*;
#(
  parameter int unsigned PG_CYC   = PG_DELAY_CYC,
  parameter int unsigned HARD_CYC = HARD_RST_CYC
)(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic supply_pwr_good,
  input  wire logic panel_reset_req_n,
  input  wire logic sw_hard_reset_req_n,
  input  wire logic kbd_soft_reset_req_n,
  input  wire logic chip_init_req_n,
  output logic      front_panel_controller_pwr_good,
  output logic      bridge_hard_req_n,
  output logic      isa_bus_reset,
  output logic      pci_reset_n,
  output logic      cpu_reset_n,
  output logic      cpu_init_n
);
  logic [4:0] pins_s;
  brc_state_t state_reg;
  brc_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic pg_s;
  logic panel_s;
  logic sw_s;
  logic kbd_s;
  logic init_s;
  logic hard_req;
  logic in_reset;
  logic [CNT_W-1:0] pg_age_reg;
  logic [CNT_W-1:0] quiet_reg;
  // Latest legal power-good point, scaled with the delay count
  localparam int unsigned PG_MAX_CYC = PG_CYC * PG_MAX_MS / PG_DELAY_MS;

  // Pins cross into the clock domain; requests idle high
  brc_sync #(.W(5), .INIT(5'h1e)) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({chip_init_req_n, kbd_soft_reset_req_n, sw_hard_reset_req_n,
                panel_reset_req_n, supply_pwr_good}),
    .sync_out (pins_s)
  );

  assign pg_s    = pins_s[0];
  assign panel_s = pins_s[1];
  assign sw_s    = pins_s[2];
  assign kbd_s   = pins_s[3];
  assign init_s  = pins_s[4];

  assign bridge_hard_req_n = panel_s;
  assign hard_req = !panel_s || !sw_s;

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      BRC_OFF:
      begin
        cnt_next = '0;
        if (pg_s)
          state_next = BRC_WAIT_PG;
      end
      BRC_WAIT_PG:
      begin
        cnt_next = cnt_reg + 1'b1;
        if (!pg_s)
          state_next = BRC_OFF;
        else if (cnt_reg == CNT_W'(PG_CYC - 1))
        begin
          state_next = BRC_RUN;
          cnt_next   = '0;
        end
      end
      BRC_RUN:
      begin
        cnt_next = '0;
        if (!pg_s)
          state_next = BRC_OFF;
        else if (hard_req)
          state_next = BRC_HARD;
      end
      BRC_HARD:
      begin
        // Held while the request stays, then a minimum pulse
        cnt_next = hard_req ? '0 : cnt_reg + 1'b1;
        if (!pg_s)
          state_next = BRC_OFF;
        else if (!hard_req && cnt_reg == CNT_W'(HARD_CYC - 1))
          state_next = BRC_RUN;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= BRC_OFF;
      cnt_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign in_reset = (state_reg != BRC_RUN);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      front_panel_controller_pwr_good <= 1'b0;
      isa_bus_reset                   <= 1'b1;
      pci_reset_n                     <= 1'b0;
      cpu_reset_n                     <= 1'b0;
      cpu_init_n                      <= 1'b1;
    end
    else
    begin
      front_panel_controller_pwr_good <= (state_next == BRC_RUN) || (state_next == BRC_HARD);
      isa_bus_reset <= (state_next != BRC_RUN);
      pci_reset_n   <= (state_next == BRC_RUN);
      cpu_reset_n   <= pci_reset_n;
      cpu_init_n    <= kbd_s && init_s;
    end
  end

  // Helper: cycles the synced supply has been good, saturating
  always_ff @(posedge clock)
  begin
    if (rst || !pg_s)
      pg_age_reg <= '0;
    else if (pg_age_reg != '1)
      pg_age_reg <= pg_age_reg + 1'b1;
  end

  // Helper: cycles since the last hard request, saturating
  always_ff @(posedge clock)
  begin
    if (rst || hard_req)
      quiet_reg <= '0;
    else if (quiet_reg != '1)
      quiet_reg <= quiet_reg + 1'b1;
  end

  // Power-good never rises before the delay has run out
  // delay bound
  pg_delay_a: assert property (@(posedge clock) disable iff (rst)
    $rose(front_panel_controller_pwr_good) |-> $past(state_reg) == BRC_WAIT_PG)
    else $error("Power good rose without delay");
  pg_window_a: assert property (@(posedge clock) disable iff (rst)
    $rose(front_panel_controller_pwr_good) |->
      (pg_age_reg >= CNT_W'(PG_CYC)) && (pg_age_reg <= CNT_W'(PG_MAX_CYC)))
    else $error("Power good outside delay window");

  bus_pair_a: assert property (@(posedge clock) disable iff (rst)
    isa_bus_reset == !pci_reset_n)
    else $error("ISA and PCI reset disagree");
  sequence hard_seen_s;
    state_reg == BRC_RUN && hard_req && pg_s;
  endsequence
  hard_bus_a: assert property (@(posedge clock) disable iff (rst)
    hard_seen_s |-> ##1 (isa_bus_reset && !pci_reset_n))
    else $error("Hard reset not driven to buses");
  hard_hold_a: assert property (@(posedge clock) disable iff (rst)
    (state_reg == BRC_HARD && hard_req && pg_s) |=> (isa_bus_reset && !pci_reset_n))
    else $error("Hard reset dropped while requested");
  // Own quiet count, so a broken state counter cannot hide
  sequence hard_done_s;
    $past(state_reg) == BRC_HARD && state_reg == BRC_RUN;
  endsequence
  hard_min_a: assert property (@(posedge clock) disable iff (rst)
    hard_done_s |-> quiet_reg >= CNT_W'(HARD_CYC))
    else $error("Hard reset released too early");

  cpu_follow_a: assert property (@(posedge clock) disable iff (rst)
    !pci_reset_n |=> !cpu_reset_n)
    else $error("Processor reset missed PCI reset");
  cpu_hold_a: assert property (@(posedge clock) disable iff (rst)
    in_reset |=> !cpu_reset_n)
    else $error("Processor left reset too early");

  init_merge_a: assert property (@(posedge clock) disable iff (rst)
    ##1 cpu_init_n == ($past(kbd_s) && $past(init_s)))
    else $error("Processor init wrong");
  // Checked against the pin, so the synchroniser is covered too
  // panel passed to bridge
  panel_pass_a: assert property (@(posedge clock) disable iff (rst)
    (!$past(rst) && !$past(rst, 2)) |-> bridge_hard_req_n == $past(panel_reset_req_n, 2))
    else $error("Panel request not passed on");

  pwr_loss_a: assert property (@(posedge clock) disable iff (rst)
    !pg_s |=> (!front_panel_controller_pwr_good && isa_bus_reset))
    else $error("Power loss not handled");
  idle_run_a: assert property (@(posedge clock) disable iff (rst)
    (state_reg == BRC_RUN && !hard_req && pg_s) |=> !isa_bus_reset)
    else $error("Spurious bus reset");
endmodule : brc_top

// ### testbench/brc_far.sv
// Far-side sources: supply, panel, software and soft-reset pins.
// Assumes the bench sets intent after a rising edge.
`timescale 1ns/1ns
module brc_far
  import brc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [4:0] want,
  input  wire logic       cpu_reset_n,
  input  wire logic       cpu_init_n,
  output logic      [4:0] pins,
  output logic            cache_valid
);
  initial pins = 5'h0f;
  initial cache_valid = 1'b0;
  always @(negedge clock)
    pins <= want;
  // init keeps cache, reset clears it
  always @(posedge clock)
    if (!cpu_reset_n)
      cache_valid <= 1'b0;
    else if (cpu_init_n)
      cache_valid <= 1'b1;
endmodule : brc_far

// ### testbench/board_reset_control_tb_top.sv
// Bench for the board reset sequencer with short counts.
// Assumes pins order {supply, panel_n, sw_n, kbd_n, chip_n}.
`timescale 1ns/1ns
module board_reset_control_tb_top
  import brc_pkg::*;
;
  localparam int unsigned PGC = 20;
  localparam int unsigned HC  = 8;
  logic       clock = 1'b0;
  logic       rst   = 1'b1;
  logic [4:0] want  = 5'h0f;
  logic [4:0] pins;
  logic       pg, brq_n, isa, pci_n, cpu_n, init_n, cache_ok;
  int         bad_count   = 0;
  int         check_count = 0;
  wire  [7:0] outs = {2'b00, pg, brq_n, isa, pci_n, cpu_n, init_n};
  always #2 clock = ~clock;
  brc_far i_far (.clock(clock), .want(want), .cpu_reset_n(cpu_n), .cpu_init_n(init_n),
    .pins(pins), .cache_valid(cache_ok));
  brc_top #(.PG_CYC(PGC), .HARD_CYC(HC)) i_dut (
    .clock(clock), .rst(rst), .supply_pwr_good(pins[4]),
    .panel_reset_req_n(pins[3]), .sw_hard_reset_req_n(pins[2]),
    .kbd_soft_reset_req_n(pins[1]), .chip_init_req_n(pins[0]),
    .front_panel_controller_pwr_good(pg), .bridge_hard_req_n(brq_n),
    .isa_bus_reset(isa), .pci_reset_n(pci_n), .cpu_reset_n(cpu_n),
    .cpu_init_n(init_n));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic t_power;
    int n;
    n = 0;
    @(posedge clock) want[4] = 1'b1;
    @(negedge clock);
    while (pg !== 1'b1 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    chk(8'(n >= PGC && n <= PGC + 5), 8'h01);
    chk(outs, 8'h35);
    @(negedge clock);
    chk(outs, 8'h37);
    $display("power-up test done");
  endtask : t_power
  // Panel goes through the bridge request; software does not
  task automatic t_hard(input int b, input logic [7:0] held);
    int n;
    n = 0;
    @(posedge clock) want[b] = 1'b0;
    repeat (5) @(negedge clock);
    chk(outs, held);
    @(posedge clock) want[b] = 1'b1;
    repeat (4) @(negedge clock);
    chk(outs, {held[7:5], 5'h19});
    while (isa !== 1'b0 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    chk(8'(n + 4 >= HC && n + 4 <= HC + 4), 8'h01);
    @(negedge clock);
    chk(outs, 8'h37);
    $display("hard reset test done");
  endtask : t_hard
  task automatic t_soft;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock) want[1:0] = 2'(i);
      repeat (4) @(negedge clock);
      chk(outs, {7'h1b, &2'(i)});
      chk({7'h00, cache_ok}, 8'h01);
    end
    $display("soft reset test done");
  endtask : t_soft
  task automatic t_drop;
    @(posedge clock) want[4] = 1'b0;
    repeat (5) @(negedge clock);
    chk(outs, 8'h19);
    $display("supply drop test done");
  endtask : t_drop
  task automatic t_reset;
    rst = 1'b1;
    repeat (3) @(negedge clock);
    chk(outs, 8'h19);
    rst = 1'b0;
    t_power;
    $display("mid-run reset test done");
  endtask : t_reset
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (12) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    chk(outs, 8'h19);
    t_power;
    t_hard(3, 8'h29);
    t_hard(2, 8'h39);
    t_soft;
    t_reset;
    t_drop;
    stop_test;
  end
  // Run needs about 130 cycles; wide margin
  initial
  begin
    #4000;
    bad_count++;
    stop_test;
  end
endmodule : board_reset_control_tb_top
